// file: verilog/sww_pkg.sv
/*
 * Constants, types and register map shared by both ends of a slave write
 * link: an interconnect fabric end that launches write transfers and a
 * slave end that captures them.
 * Assumes one rising-edge clock and an active-low asynchronous reset.
 */
package sww_pkg;

    // ==========================================================
    // link widths
    localparam int SWW_AW    = 4;
    localparam int SWW_DW    = 32;
    localparam int SWW_BW    = 4;
    localparam int SWW_WORDS = 16;
    localparam int SWW_CW    = 4;
    localparam int SWW_LW    = 8;

    // ==========================================================
    // modes and states
    typedef enum logic [0:0] {
        SWW_FIXED    = 1'b0,
        SWW_VARIABLE = 1'b1
    } sww_wait_mode_t;

    typedef enum logic [1:0] {
        SWW_IDLE   = 2'b00,
        SWW_SETUP  = 2'b01,
        SWW_STROBE = 2'b10,
        SWW_HOLD   = 2'b11
    } sww_fab_state_t;

    // ==========================================================
    // controller register map (byte addresses)
    localparam logic [7:0] SWW_CTRL_OFS  = 8'h00;
    localparam logic [7:0] SWW_TIM_OFS   = 8'h04;
    localparam logic [7:0] SWW_ADDR_OFS  = 8'h08;
    localparam logic [7:0] SWW_WDATA_OFS = 8'h0c;
    localparam logic [7:0] SWW_BE_OFS    = 8'h10;
    localparam logic [7:0] SWW_STAT_OFS  = 8'h14;

    localparam int SWW_CTRL_MODE_BIT  = 0;
    localparam int SWW_CTRL_START_BIT = 4;
    localparam int SWW_TIM_SETUP_LSB  = 0;
    localparam int SWW_TIM_WAIT_LSB   = 8;
    localparam int SWW_TIM_HOLD_LSB   = 16;
    localparam int SWW_STAT_BUSY_BIT  = 0;
    localparam int SWW_STAT_DONE_BIT  = 1;
    localparam int SWW_STAT_LEN_LSB   = 16;

    // ==========================================================
    // reset values and timing counts
    localparam logic [SWW_CW-1:0] SWW_TIM_RST  = 4'h0;
    localparam logic [SWW_BW-1:0] SWW_BE_RST   = 4'hf;
    localparam logic [SWW_CW-1:0] SWW_FIX_WAIT = 4'h1;
    localparam logic [SWW_CW-1:0] SWW_VAR_LAT  = 4'h3;

endpackage : sww_pkg

// file: verilog/sww_if.sv
/*
 * Write link between the interconnect fabric end and the slave end.
 * Assumes both ends run on the same clock, supplied to each module.
 */
`timescale 1ns/1ps
interface sww_if;
    import sww_pkg::*;

    logic [SWW_AW-1:0] address;
    logic [SWW_DW-1:0] writedata;
    logic [SWW_BW-1:0] byteenable;
    logic              write;
    logic              chipselect;
    logic              waitrequest;

    modport fabric (
        output address,
        output writedata,
        output byteenable,
        output write,
        output chipselect,
        input  waitrequest
    );

    modport slave (
        input  address,
        input  writedata,
        input  byteenable,
        input  write,
        input  chipselect,
        output waitrequest
    );

endinterface : sww_if

// file: verilog/sww_slave.sv
/*
 * Slave end: a 16-word write-only memory with fixed or variable wait
 * states, byte-lane enables and a user-side read port.
 * Assumes link inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module sww_slave
    import sww_pkg::*;
#(
    parameter logic        VARIABLE_WAIT = 1'b0,
    parameter logic [3:0]  FIX_WAIT      = SWW_FIX_WAIT,
    parameter logic [3:0]  VAR_LAT       = SWW_VAR_LAT,
    parameter logic        USE_BYTE_EN   = 1'b1
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    sww_if.slave                   bus,
    input  wire logic [SWW_AW-1:0] rd_addr,
    output logic      [SWW_DW-1:0] rd_data,
    output logic                   wr_pulse
);

    typedef struct packed {
        logic [SWW_WORDS-1:0][SWW_DW-1:0] mem;
        logic [SWW_CW-1:0]                cnt;
        logic [SWW_DW-1:0]                rdata;
        logic                             wpulse;
    } sww_slv_t;

    sww_slv_t          r_reg;
    sww_slv_t          r_next;
    logic              active;
    logic              stall;
    logic              capture;
    logic [SWW_DW-1:0] merged;

    // ==========================================================
    // stall and capture decision
    assign active = bus.chipselect & bus.write;
    assign stall  = VARIABLE_WAIT & active & (r_reg.cnt != VAR_LAT);
    assign bus.waitrequest = stall;
    assign capture = active & (VARIABLE_WAIT ? ~stall : (r_reg.cnt == FIX_WAIT));

    // ==========================================================
    // byte-lane merge
    genvar g;
    generate
        for (g = 0; g < SWW_BW; g++) begin : g_lane
            assign merged[8*g +: 8] = (bus.byteenable[g] | ~USE_BYTE_EN)
                                    ? bus.writedata[8*g +: 8]
                                    : r_reg.mem[bus.address][8*g +: 8];
        end
    endgenerate

    always_comb begin
        r_next        = r_reg;
        r_next.wpulse = capture;
        r_next.rdata  = r_reg.mem[rd_addr];
        if (capture) begin
            r_next.mem[bus.address] = merged;
            r_next.cnt              = '0;
        end else if (active) begin
            r_next.cnt = r_reg.cnt + 4'h1;
        end else begin
            r_next.cnt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rd_data  = r_reg.rdata;
    assign wr_pulse = r_reg.wpulse;

endmodule : sww_slave

// file: verilog/sww_fabric.sv
/*
 * Fabric end: takes a write order over APB and drives one slave write
 * with setup, fixed wait states and hold, or variable wait states alone, then reports
 * busy, done and the transfer length.
 * Assumes the slave end shares pclk; waitrequest is same-clock logic.
 */
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module sww_fabric
    import sww_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    sww_if.fabric            bus
);

    typedef struct packed {
        sww_fab_state_t    st;
        sww_wait_mode_t    mode;
        logic [SWW_CW-1:0] setup;
        logic [SWW_CW-1:0] waitc;
        logic [SWW_CW-1:0] hold;
        logic [SWW_AW-1:0] adr_cfg;
        logic [SWW_DW-1:0] wd_cfg;
        logic [SWW_BW-1:0] be_cfg;
        logic              done;
        logic [SWW_LW-1:0] len;
        logic [SWW_LW-1:0] len_cnt;
        logic [SWW_CW-1:0] cnt;
        logic              cs;
        logic              wr;
        logic [SWW_AW-1:0] adr;
        logic [SWW_DW-1:0] wd;
        logic [SWW_BW-1:0] be;
        logic [31:0]       rdata;
        logic              slverr;
    } sww_fab_t;

    sww_fab_t r_reg;
    sww_fab_t r_next;
    logic     acc;
    logic     busy;

    assign acc  = psel & penable;
    assign busy = (r_reg.st != SWW_IDLE);

    // ==========================================================
    // register file and transfer sequencer
    always_comb begin
        logic              go;
        logic              fin;
        logic              ends;
        logic [SWW_CW-1:0] su;
        logic [SWW_CW-1:0] ho;
        go     = 1'b0;
        fin    = 1'b0;
        ends   = 1'b0;
        su     = '0;
        ho     = '0;
        r_next = r_reg;

        // read data prepared in the setup cycle
        if (psel & ~penable) begin
            r_next.slverr = 1'b0;
            case (paddr)
                SWW_CTRL_OFS:  r_next.rdata = {31'h0, r_reg.mode};
                SWW_TIM_OFS:   r_next.rdata = {12'h0, r_reg.hold, 4'h0, r_reg.waitc,
                                               4'h0, r_reg.setup};
                SWW_ADDR_OFS:  r_next.rdata = {28'h0, r_reg.adr_cfg};
                SWW_WDATA_OFS: r_next.rdata = r_reg.wd_cfg;
                SWW_BE_OFS:    r_next.rdata = {28'h0, r_reg.be_cfg};
                SWW_STAT_OFS:  r_next.rdata = {8'h0, r_reg.len, 14'h0, r_reg.done, busy};
                default: begin
                    r_next.rdata  = 32'h0;
                    r_next.slverr = 1'b1;
                end
            endcase
        end

        // writes; configuration is frozen while a transfer runs
        if (acc & pwrite & ~busy) begin
            case (paddr)
                SWW_CTRL_OFS: begin
                    r_next.mode = sww_wait_mode_t'(pwdata[SWW_CTRL_MODE_BIT]);
                    go          = pwdata[SWW_CTRL_START_BIT];
                end
                SWW_TIM_OFS: begin
                    r_next.setup = pwdata[SWW_TIM_SETUP_LSB +: SWW_CW];
                    r_next.waitc = pwdata[SWW_TIM_WAIT_LSB +: SWW_CW];
                    r_next.hold  = pwdata[SWW_TIM_HOLD_LSB +: SWW_CW];
                end
                SWW_ADDR_OFS:  r_next.adr_cfg = pwdata[SWW_AW-1:0];
                SWW_WDATA_OFS: r_next.wd_cfg  = pwdata;
                SWW_BE_OFS:    r_next.be_cfg  = pwdata[SWW_BW-1:0];
                default: begin
                end
            endcase
        end

        // variable waits run with no setup or hold
        su = (r_next.mode == SWW_VARIABLE) ? 4'h0 : r_next.setup;
        ho = (r_reg.mode == SWW_VARIABLE) ? 4'h0 : r_reg.hold;

        case (r_reg.st)
            SWW_IDLE: begin
                if (go) begin
                    r_next.cs      = 1'b1;
                    r_next.adr     = r_next.adr_cfg;
                    r_next.wd      = r_next.wd_cfg;
                    r_next.be      = r_next.be_cfg;
                    r_next.done    = 1'b0;
                    r_next.len_cnt = 8'h01;
                    r_next.cnt     = '0;
                    if (su == 4'h0) begin
                        r_next.wr = 1'b1;
                        r_next.st = SWW_STROBE;
                    end else begin
                        r_next.cnt = su - 4'h1;
                        r_next.st  = SWW_SETUP;
                    end
                end
            end
            SWW_SETUP: begin
                r_next.len_cnt = r_reg.len_cnt + 8'h01;
                if (r_reg.cnt == 4'h0) begin
                    r_next.wr = 1'b1;
                    r_next.st = SWW_STROBE;
                end else begin
                    r_next.cnt = r_reg.cnt - 4'h1;
                end
            end
            SWW_STROBE: begin
                if (r_reg.mode == SWW_VARIABLE) begin
                    ends = ~bus.waitrequest;
                end else begin
                    ends = (r_reg.cnt == r_reg.waitc);
                end
                if (!ends) begin
                    r_next.cnt     = r_reg.cnt + 4'h1;
                    r_next.len_cnt = r_reg.len_cnt + 8'h01;
                end else if (ho == 4'h0) begin
                    fin = 1'b1;
                end else begin
                    r_next.wr      = 1'b0;
                    r_next.cnt     = ho - 4'h1;
                    r_next.len_cnt = r_reg.len_cnt + 8'h01;
                    r_next.st      = SWW_HOLD;
                end
            end
            SWW_HOLD: begin
                if (r_reg.cnt == 4'h0) begin
                    fin = 1'b1;
                end else begin
                    r_next.cnt     = r_reg.cnt - 4'h1;
                    r_next.len_cnt = r_reg.len_cnt + 8'h01;
                end
            end
            default: begin
                r_next.st = SWW_IDLE;
            end
        endcase

        if (fin) begin
            r_next.cs   = 1'b0;
            r_next.wr   = 1'b0;
            r_next.adr  = '0;
            r_next.wd   = '0;
            r_next.be   = '0;
            r_next.st   = SWW_IDLE;
            r_next.done = 1'b1;
            r_next.len  = r_reg.len_cnt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg        <= '0;
            r_reg.setup  <= SWW_TIM_RST;
            r_reg.waitc  <= SWW_TIM_RST;
            r_reg.hold   <= SWW_TIM_RST;
            r_reg.be_cfg <= SWW_BE_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // outputs
    assign prdata         = r_reg.rdata;
    assign pready         = acc;
    assign pslverr        = acc & r_reg.slverr;
    assign bus.chipselect = r_reg.cs;
    assign bus.write      = r_reg.wr;
    assign bus.address    = r_reg.adr;
    assign bus.writedata  = r_reg.wd;
    assign bus.byteenable = r_reg.be;

endmodule : sww_fabric

// file: tb/sww_props.sv
/*
 * Checker for two write links: a fixed-wait pair and a variable-wait pair.
 * Assumes one fixed wait state, a three-cycle stall and idle links at zero.
 */
`timescale 1ns/1ps
module sww_props
    import sww_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [SWW_AW-1:0] address,
    input wire logic [SWW_DW-1:0] writedata,
    input wire logic [SWW_BW-1:0] byteenable,
    input wire logic              write,
    input wire logic              chipselect,
    input wire logic              waitrequest,
    input wire logic              chipselect_v,
    input wire logic              write_v,
    input wire logic              waitrequest_v
);
    // ==========================================================
    // cycles of the transfer in flight
    logic [7:0] cs_cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_cnt_reg <= 8'h00;
        end else begin
            cs_cnt_reg <= chipselect ? cs_cnt_reg + 8'h01 : 8'h00;
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_strobe_two;
        write ##1 !write;
    endsequence

    sequence s_link_idle;
        !write && address == 4'h0 && writedata == 32'h0 && byteenable == 4'h0;
    endsequence

    a_wait_idle: assert property ((!(chipselect && write) |-> !waitrequest) and
        (!(chipselect_v && write_v) |-> !waitrequest_v))
        else $error("waitrequest outside a strobe");
    a_stall_first: assert property ($rose(chipselect_v && write_v) |-> waitrequest_v)
        else $error("stall not raised in first cycle");
    a_stall_bound: assert property (waitrequest_v |-> ##[1:3] !waitrequest_v)
        else $error("stall held too long");
    a_stall_end: assert property ($fell(waitrequest_v) && chipselect_v |=> !chipselect_v)
        else $error("transfer not ended after stall");
    a_strobe_in_cs: assert property (write |-> chipselect)
        else $error("strobe without select");
    a_sig_stable: assert property (chipselect && $past(chipselect) |->
        $stable(address) && $stable(writedata) && $stable(byteenable))
        else $error("transfer signals moved");
    a_drop_together: assert property ($fell(chipselect) |-> s_link_idle)
        else $error("signals not dropped together");
    a_fixed_strobe: assert property ($rose(write) |=> s_strobe_two)
        else $error("strobe length wrong for one wait");
    a_hold_low: assert property ($fell(write) && chipselect |=> !write)
        else $error("strobe raised again in hold");
    a_strobe_start: assert property ($rose(chipselect) |-> ##[0:15] write)
        else $error("strobe missing after setup");
    a_len_bound: assert property (cs_cnt_reg <= 8'h2e)
        else $error("transfer too long");

endmodule : sww_props

// file: tb/sww_tb_top.sv
/*
 * Testbench: two fabric/slave pairs, fixed (pair 0) and variable (pair 1),
 * driven over APB. Assumes the register map and timings of sww_pkg.
 */
`timescale 1ns/1ps
module sww_tb_top;
    import sww_pkg::*;

    logic        pclk;
    logic        presetn;
    logic [1:0]  psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata [2];
    logic [1:0]  pready;
    logic [1:0]  pslverr;
    logic [3:0]  rd_addr [2];
    logic [31:0] rd_data [2];
    logic [1:0]  wr_pulse;
    logic [31:0] mem [2][16];
    int          pulses [2];
    int          waits;
    int          error_cnt;
    int          num_checks;

    sww_if bus [2] ();

    for (genvar g = 0; g < 2; g++) begin : pair
        sww_fabric sww_fabric_i (.pclk(pclk), .presetn(presetn), .psel(psel[g]),
            .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
            .prdata(prdata[g]), .pready(pready[g]), .pslverr(pslverr[g]), .bus(bus[g]));
        sww_slave #(.VARIABLE_WAIT(g == 1)) sww_slave_i (.pclk(pclk), .presetn(presetn),
            .bus(bus[g]), .rd_addr(rd_addr[g]), .rd_data(rd_data[g]), .wr_pulse(wr_pulse[g]));
    end

    sww_props sww_props_i (.pclk(pclk), .presetn(presetn), .address(bus[0].address),
        .writedata(bus[0].writedata), .byteenable(bus[0].byteenable), .write(bus[0].write),
        .chipselect(bus[0].chipselect), .waitrequest(bus[0].waitrequest),
        .chipselect_v(bus[1].chipselect), .write_v(bus[1].write),
        .waitrequest_v(bus[1].waitrequest));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (wr_pulse[0] === 1'b1) pulses[0]++;
        if (wr_pulse[1] === 1'b1) pulses[1]++;
        if (bus[1].waitrequest === 1'b1) waits++;
    end

    // ==========================================================
    // shared tasks
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input int s, input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel[s] <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready[s] !== 1'b1 && n < 20);
        if (pready[s] !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
        r = prdata[s];
        e = pslverr[s];
        psel    <= 2'b00;
        penable <= 1'b0;
    endtask : apb

    // program, start, await done, then judge length, capture and lanes
    task automatic xfer(input int s, input logic [3:0] su, input logic [3:0] hd,
                        input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                        input bit poke);
        logic [31:0] r;
        logic        e;
        logic [31:0] len;
        int          n;
        int          p0;
        int          w0;
        p0 = pulses[s];
        w0 = waits;
        apb(s, 1'b1, SWW_TIM_OFS, {12'h0, hd, 4'h0, SWW_FIX_WAIT, 4'h0, su}, r, e);
        apb(s, 1'b1, SWW_ADDR_OFS, {28'h0, a}, r, e);
        apb(s, 1'b1, SWW_WDATA_OFS, d, r, e);
        apb(s, 1'b1, SWW_BE_OFS, {28'h0, be}, r, e);
        apb(s, 1'b1, SWW_CTRL_OFS, {27'h0, 1'b1, 3'h0, s[0]}, r, e);
        if (poke) begin
            apb(s, 1'b1, SWW_ADDR_OFS, 32'h2, r, e);
            apb(s, 1'b0, SWW_STAT_OFS, 32'h0, r, e);
            chk({31'h0, r[0]}, 32'h1);
        end
        n = 0;
        do begin
            apb(s, 1'b0, SWW_STAT_OFS, 32'h0, r, e);
            n++;
        end while (r[1] !== 1'b1 && n < 40);
        if (r[1] !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
        len = s ? 32'(SWW_VAR_LAT) + 1 : 32'(su) + 32'(hd) + 32'(SWW_FIX_WAIT) + 1;
        chk({24'h0, r[23:16]}, len);
        chk({31'h0, r[0]}, 32'h0);
        if (poke) begin
            apb(s, 1'b0, SWW_ADDR_OFS, 32'h0, r, e);
            chk(r, {28'h0, a});
        end
        for (int g = 0; g < 4; g++) if (be[g]) mem[s][a][8*g+:8] = d[8*g+:8];
        rd_addr[s] <= a;
        repeat (2) @(posedge pclk);
        chk(rd_data[s], mem[s][a]);
        chk(32'(pulses[s] - p0), 32'h1);
        if (s == 1) chk(32'(waits - w0), 32'(SWW_VAR_LAT));
    endtask : xfer

    // ==========================================================
    // scenarios
    task automatic t_reset;
        logic [31:0] r;
        logic        e;
        logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
        for (int i = 0; i < 7; i++) begin
            apb(0, 1'b0, ofs[i], 32'h0, r, e);
            chk(r, (i == 4) ? 32'hf : 32'h0);
            chk({31'h0, e}, (i == 6) ? 32'h1 : 32'h0);
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_fixed;
        logic [3:0] bes [5] = '{4'hf, 4'h3, 4'hc, 4'h1, 4'h4};
        for (int i = 0; i < 5; i++) begin
            xfer(0, 4'(i % 3), 4'((i * 3) % 4), (i == 4) ? 4'hf : 4'(i % 2 + 3),
                 32'ha5a50000 + 32'(i * 32'h01010101), bes[i], 1'b0);
        end
        $display("test fixed done");
    endtask : t_fixed

    task automatic t_var;
        xfer(1, 4'h2, 4'h2, 4'h7, 32'hcafe0001, 4'hf, 1'b0);
        xfer(1, 4'h0, 4'h0, 4'h7, 32'h12345678, 4'h8, 1'b0);
        $display("test variable done");
    endtask : t_var

    task automatic t_busy;
        xfer(0, 4'h3, 4'h3, 4'h9, 32'h0badf00d, 4'hf, 1'b1);
        $display("test busy done");
    endtask : t_busy

    initial begin
        presetn    = 1'b0;
        psel       = 2'b00;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        rd_addr[0] = 4'h0;
        rd_addr[1] = 4'h0;
        mem        = '{default: '0};
        pulses     = '{0, 0};
        waits      = 0;
        error_cnt  = 0;
        num_checks = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fixed();
        t_var();
        t_busy();
        end_of_test();
    end

endmodule : sww_tb_top
